//--- verilog/dvhm_pkg.sv
// Constants, attenuation table and shared helpers for the volume and mix register bank
package dvhm_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W            = 10;
    localparam int         DATA_W            = 32;
    localparam logic [7:0] IDX_COUPLE        = 8'h29;
    localparam logic [7:0] IDX_RIGHT_VOL     = 8'h2C;
    localparam logic [7:0] IDX_MIX_SEC_LEFT  = 8'h2D;
    localparam logic [7:0] IDX_MIX_LEFT_AMP  = 8'h2E;
    localparam logic [7:0] IDX_MIX_LEFT_PLAY = 8'h2F;
    localparam logic [7:0] IDX_MIX_SEC_RIGHT = 8'h30;
    localparam logic [7:0] IDX_STATUS        = 8'h31;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int         ROUTE_N           = 4;
    localparam int         ROUTE_MAX         = 7;
    localparam int         MUTE_BIT          = 7;
    localparam int         ROUTE_EN_BIT      = 7;
    localparam int         STAT_ROUTE_LSB    = 8;
    localparam logic [7:0] RIGHT_VOL_RST     = 8'h80;
    localparam logic [7:0] MIX_RST           = 8'h00;
    localparam logic [1:0] COUPLE_RST        = 2'h0;
    localparam logic [1:0] COUPLE_R_FOLLOW_L = 2'h2;

    // ------------------------------------------------------------------
    // Attenuation, in tenths of a decibel
    // ------------------------------------------------------------------
    localparam logic [9:0] ATTEN_STEP        = 10'h005;
    localparam logic [9:0] MUTE_ATTEN        = 10'h3FF;
    localparam logic [6:0] TAB_BASE          = 7'h25;
    localparam logic [6:0] CODE_LAST_GAIN    = 7'h75;
    localparam logic [6:0] CODE_FIRST_MUTE   = 7'h76;

    // Irregular part of the output-stage curve, codes 37..117
    localparam logic [9:0] ATTEN_TAB [0:80] = '{
        10'd186, 10'd191, 10'd196, 10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226,
        10'd231, 10'd236, 10'd241, 10'd246, 10'd251, 10'd256, 10'd261, 10'd266, 10'd271,
        10'd276, 10'd281, 10'd286, 10'd291, 10'd296, 10'd301, 10'd306, 10'd311, 10'd316,
        10'd321, 10'd326, 10'd331, 10'd336, 10'd341, 10'd346, 10'd351, 10'd357, 10'd361,
        10'd367, 10'd371, 10'd377, 10'd382, 10'd387, 10'd392, 10'd397, 10'd402, 10'd407,
        10'd412, 10'd417, 10'd422, 10'd427, 10'd432, 10'd438, 10'd443, 10'd448, 10'd452,
        10'd458, 10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493, 10'd500,
        10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527, 10'd537, 10'd542, 10'd553,
        10'd567, 10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687, 10'd722, 10'd783
    };

    // Linear half-dB scale, shared by the digital gain and the output-stage low codes
    function automatic logic [9:0] dvhm_half_db(input logic [6:0] code);
        return 10'(code) * ATTEN_STEP;
    endfunction

    function automatic logic [9:0] dvhm_stage_atten(input logic [6:0] code);
        if (code < TAB_BASE) begin
            return dvhm_half_db(code);
        end else if (code <= CODE_LAST_GAIN) begin
            return ATTEN_TAB[7'(code - TAB_BASE)];
        end
        return MUTE_ATTEN;
    endfunction

    function automatic logic dvhm_writable(input logic [7:0] idx);
        return (idx == IDX_COUPLE) || ((idx >= IDX_RIGHT_VOL) && (idx <= IDX_MIX_SEC_RIGHT));
    endfunction

endpackage

//--- verilog/dvhm_route_if.sv
// Carrier between the register bank and one output-stage route control
interface dvhm_route_if;
    logic       enable;
    logic [6:0] code;
    logic       active;
    logic       muted;
    logic [9:0] atten;

    modport ctrl  (output enable, output code, input active, input muted, input atten);
    modport stage (input enable, input code, output active, output muted, output atten);
endinterface

//--- verilog/dvhm_route_gain.sv
// One output-stage volume control: route enable plus table attenuation
module dvhm_route_gain (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    dvhm_route_if.stage rt
);

    // ------------------------------------------------------------------
    // Gain lookup
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rt.active <= 1'b0;
            rt.muted  <= 1'b1;
            rt.atten  <= dvhm_pkg::MUTE_ATTEN;
        end else begin
            // Disabled route is forced silent so a stale code cannot leak
            rt.active <= rt.enable;
            rt.muted  <= !rt.enable || (rt.code >= dvhm_pkg::CODE_FIRST_MUTE);
            rt.atten  <= rt.enable ? dvhm_pkg::dvhm_stage_atten(rt.code)
                                   : dvhm_pkg::MUTE_ATTEN;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_last_gain_code: assert property (@(posedge aclk) disable iff (!aresetn)
        rt.enable && rt.code == dvhm_pkg::CODE_LAST_GAIN |=> rt.atten == 10'd783 && !rt.muted)
        else $error("code 117 not at -78.3 dB");

    a_mute_codes: assert property (@(posedge aclk) disable iff (!aresetn)
        rt.enable && rt.code >= dvhm_pkg::CODE_FIRST_MUTE |=> rt.muted && rt.active)
        else $error("mute code did not mute");

    a_disabled_silent: assert property (@(posedge aclk) disable iff (!aresetn)
        !rt.enable |=> !rt.active && rt.muted && rt.atten == dvhm_pkg::MUTE_ATTEN)
        else $error("disabled route still contributes");

endmodule

//--- verilog/dvhm_regs.sv
// Playback volume and left headphone mix register bank on AXI4-Lite
module dvhm_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,

    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,

    input  wire logic [6:0]  left_gain_code,
    output logic [6:0]       dac_right_gain_code,
    output logic             dac_right_mute,
    output logic [9:0]       dac_right_atten_tenth_db,
    output logic [3:0]       hp_route_on,
    output logic [3:0]       hp_route_muted,
    output logic [39:0]      hp_route_atten_tenth_db
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic       aw_full_q;
    logic [7:0] aw_idx_q;
    logic       w_full_q;
    logic [7:0] w_data_q;
    logic       w_strb0_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic       rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic       wr_go;
    logic       wr_en;
    logic [7:0] mix_off;
    logic [7:0] ar_idx;
    logic [31:0] rd_word_d;
    logic       rd_hit_d;
    logic [7:0] right_vol_q;
    logic [1:0] couple_q;
    logic [7:0] mix_q [0:3];
    logic [6:0] right_eff_d;

    dvhm_route_if rt_if [dvhm_pkg::ROUTE_N] ();

    // ------------------------------------------------------------------
    // Write address and data capture
    // ------------------------------------------------------------------
    // Address and data are held apart, so either may arrive first
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign wr_go         = aw_full_q && w_full_q && !bvalid_q;
    assign wr_en         = wr_go && w_strb0_q;
    assign mix_off       = 8'(aw_idx_q - dvhm_pkg::IDX_MIX_SEC_LEFT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_idx_q  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[9:2];
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q  <= 1'b1;
            w_data_q  <= s_axi_wdata[7:0];
            w_strb0_q <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_full_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= dvhm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= dvhm_pkg::dvhm_writable(aw_idx_q) ? dvhm_pkg::RESP_OKAY
                                                           : dvhm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------------
    // Right playback volume and coupling
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            right_vol_q <= dvhm_pkg::RIGHT_VOL_RST;
        end else if (wr_en && aw_idx_q == dvhm_pkg::IDX_RIGHT_VOL) begin
            right_vol_q <= w_data_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            couple_q <= dvhm_pkg::COUPLE_RST;
        end else if (wr_en && aw_idx_q == dvhm_pkg::IDX_COUPLE) begin
            couple_q <= w_data_q[1:0];
        end
    end

    // Other coupling codes leave right on its own setting
    assign right_eff_d = (couple_q == dvhm_pkg::COUPLE_R_FOLLOW_L) ? left_gain_code
                                                                    : right_vol_q[6:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_right_gain_code      <= 7'h00;
            dac_right_mute           <= 1'b1;
            dac_right_atten_tenth_db <= 10'h000;
        end else begin
            dac_right_gain_code      <= right_eff_d;
            dac_right_mute           <= right_vol_q[dvhm_pkg::MUTE_BIT];
            dac_right_atten_tenth_db <= dvhm_pkg::dvhm_half_db(right_eff_d);
        end
    end

    // ------------------------------------------------------------------
    // Left headphone mix routes
    // ------------------------------------------------------------------
    // Route order: second left line, left amp, left playback, second right line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < dvhm_pkg::ROUTE_N; i++) begin
                mix_q[i] <= dvhm_pkg::MIX_RST;
            end
        end else if (wr_en && mix_off < 8'(dvhm_pkg::ROUTE_N)) begin
            mix_q[mix_off[1:0]] <= w_data_q;
        end
    end

    // One control per source for this driver; the other six live elsewhere
    for (genvar g = 0; g < dvhm_pkg::ROUTE_N; g++) begin : g_route
        assign rt_if[g].enable = mix_q[g][dvhm_pkg::ROUTE_EN_BIT];
        assign rt_if[g].code   = mix_q[g][6:0];

        dvhm_route_gain u_gain (
            .aclk    (aclk),
            .aresetn (aresetn),
            .rt      (rt_if[g])
        );

        assign hp_route_on[g]                   = rt_if[g].active;
        assign hp_route_muted[g]                = rt_if[g].muted;
        assign hp_route_atten_tenth_db[g*10+:10] = rt_if[g].atten;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign ar_idx        = s_axi_araddr[9:2];

    always_comb begin
        rd_word_d = 32'h0000_0000;
        rd_hit_d  = 1'b1;
        case (ar_idx)
            dvhm_pkg::IDX_COUPLE:        rd_word_d[1:0] = couple_q;
            dvhm_pkg::IDX_RIGHT_VOL:     rd_word_d[7:0] = right_vol_q;
            dvhm_pkg::IDX_MIX_SEC_LEFT:  rd_word_d[7:0] = mix_q[0];
            dvhm_pkg::IDX_MIX_LEFT_AMP:  rd_word_d[7:0] = mix_q[1];
            dvhm_pkg::IDX_MIX_LEFT_PLAY: rd_word_d[7:0] = mix_q[2];
            dvhm_pkg::IDX_MIX_SEC_RIGHT: rd_word_d[7:0] = mix_q[3];
            dvhm_pkg::IDX_STATUS: begin
                rd_word_d[6:0]                        = dac_right_gain_code;
                rd_word_d[dvhm_pkg::MUTE_BIT]         = dac_right_mute;
                rd_word_d[dvhm_pkg::STAT_ROUTE_LSB+:4] = hp_route_on;
            end
            default: rd_hit_d = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= dvhm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word_d;
            rresp_q  <= rd_hit_d ? dvhm_pkg::RESP_OKAY : dvhm_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_mix_write(k);
        wr_en && aw_idx_q == 8'(dvhm_pkg::IDX_MIX_SEC_LEFT + k);
    endsequence

    sequence s_route_lands(k);
        ##1 (mix_q[k] == $past(w_data_q))
        ##1 (hp_route_on[k] == $past(w_data_q[7], 2));
    endsequence

    property p_route_write(k);
        s_mix_write(k) |-> s_route_lands(k);
    endproperty

    a_mute_at_reset: assert property (
        $rose(aresetn) |-> right_vol_q[dvhm_pkg::MUTE_BIT] && dac_right_mute)
        else $error("right mute not set after reset");

    a_right_half_db: assert property (
        couple_q != dvhm_pkg::COUPLE_R_FOLLOW_L ##1 couple_q != dvhm_pkg::COUPLE_R_FOLLOW_L
        |-> dac_right_atten_tenth_db == 10'($past(right_vol_q[6:0])) * 10'd5)
        else $error("right gain not half-dB per code");

    // Skips the edge after a one-cycle reset, where the enables were not yet cleared
    a_route_limit: assert property (
        $past(aresetn) |-> hp_route_on == $past({mix_q[3][7], mix_q[2][7], mix_q[1][7],
                                                 mix_q[0][7]}))
        else $error("route active flags differ from enables");

    a_second_left_route: assert property (p_route_write(0))
        else $error("second left line route not applied");

    a_left_amp_route: assert property (p_route_write(1))
        else $error("left amp route not applied");

    a_left_play_route: assert property (p_route_write(2))
        else $error("left playback route not applied");

    a_second_right_route: assert property (p_route_write(3))
        else $error("second right line route not applied");

    a_right_follow: assert property (
        couple_q == dvhm_pkg::COUPLE_R_FOLLOW_L |=> dac_right_gain_code == $past(left_gain_code))
        else $error("right gain not tracking left");

endmodule

//--- dv/testbench.sv
// Self-checking bench for the volume and headphone mix register bank
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Clock, reset and design ports
    // ----------------------------------------------------------------
    logic        aclk      = 1'b0;
    logic        aresetn   = 1'b0;
    logic        awvalid   = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, mute;
    logic [9:0]  awaddr    = 10'h000, araddr = 10'h000;
    logic [9:0]  ratt;
    logic [2:0]  awprot    = 3'h0, arprot = 3'h0;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] rdata;
    logic [3:0]  wstrb     = 4'h0;
    logic [3:0]  ron, rmuted;
    logic [1:0]  bresp, rresp;
    logic [6:0]  left_gain = 7'h00;
    logic [6:0]  rgain;
    logic [39:0] hatt;
    logic [7:0]  mdl [0:255];
    int          n_fail    = 0;
    int          n_checks  = 0;
    // Output-stage curve in tenths of a dB, codes 37..117
    int          tab [0:80] = '{186, 191, 196, 201, 206, 211, 216, 221, 226, 231, 236, 241,
        246, 251, 256, 261, 266, 271, 276, 281, 286, 291, 296, 301, 306, 311, 316, 321, 326,
        331, 336, 341, 346, 351, 357, 361, 367, 371, 377, 382, 387, 392, 397, 402, 407, 412,
        417, 422, 427, 432, 438, 443, 448, 452, 458, 462, 467, 474, 479, 482, 487, 493, 500,
        503, 510, 514, 518, 522, 527, 537, 542, 553, 567, 583, 602, 627, 643, 662, 687, 722,
        783};

    always #4 aclk = ~aclk;

    dvhm_regs i_dvhm_regs (
        .aclk                     (aclk),
        .aresetn                  (aresetn),
        .s_axi_awvalid            (awvalid),
        .s_axi_awready            (awready),
        .s_axi_awaddr             (awaddr),
        .s_axi_awprot             (awprot),
        .s_axi_wvalid             (wvalid),
        .s_axi_wready             (wready),
        .s_axi_wdata              (wdata),
        .s_axi_wstrb              (wstrb),
        .s_axi_bvalid             (bvalid),
        .s_axi_bready             (bready),
        .s_axi_bresp              (bresp),
        .s_axi_arvalid            (arvalid),
        .s_axi_arready            (arready),
        .s_axi_araddr             (araddr),
        .s_axi_arprot             (arprot),
        .s_axi_rvalid             (rvalid),
        .s_axi_rready             (rready),
        .s_axi_rdata              (rdata),
        .s_axi_rresp              (rresp),
        .left_gain_code           (left_gain),
        .dac_right_gain_code      (rgain),
        .dac_right_mute           (mute),
        .dac_right_atten_tenth_db (ratt),
        .hp_route_on              (ron),
        .hp_route_muted           (rmuted),
        .hp_route_atten_tenth_db  (hatt)
    );

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] idx);
        return (idx == 8'h29) || ((idx >= 8'h2C) && (idx <= 8'h30));
    endfunction

    // Disabled route reads as full mute, whatever its code
    function automatic logic [9:0] stage(input logic [7:0] m);
        if (!m[7]) return 10'h3FF;
        if (m[6:0] < 7'h25) return 10'(m[6:0] * 5);
        if (m[6:0] < 7'h76) return 10'(tab[m[6:0] - 37]);
        return 10'h3FF;
    endfunction

    function automatic logic [6:0] eff();
        return (mdl[8'h29][1:0] == 2'h2) ? left_gain : mdl[8'h2C][6:0];
    endfunction

    task automatic chk_port(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_outs();
        logic [7:0] m;
        chk_port("right_gain", 10'(eff()), 10'(rgain));
        chk_port("right_mute", 10'(mdl[8'h2C][7]), 10'(mute));
        chk_port("right_atten", 10'(eff()) * 10'h005, ratt);
        for (int g = 0; g < 4; g++) begin
            m = mdl[8'h2D + g];
            chk_port("route_on", 10'(m[7]), 10'(ron[g]));
            chk_port("route_muted", 10'(stage(m) == 10'h3FF), 10'(rmuted[g]));
            chk_port("route_atten", stage(m), hatt[g*10+:10]);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        awprot <= 3'($urandom);
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        arprot <= 3'($urandom);
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_write({idx, 2'b00}, d, s, r);
        chk_bus("bresp", mapped(idx) ? 32'h0 : 32'h2, 32'(r));
        if (mapped(idx) && s[0]) mdl[idx] = d[7:0];
        repeat (2) @(posedge aclk);
        check_outs();
    endtask

    task automatic rd(input logic [7:0] idx);
        logic [31:0] e;
        logic [31:0] d;
        logic [1:0]  er;
        logic [1:0]  r;
        e = 32'h0;
        er = 2'h0;
        if (mapped(idx)) e = {24'h0, mdl[idx]};
        else if (idx == dvhm_pkg::IDX_STATUS) e = {20'h0, mdl[8'h30][7], mdl[8'h2F][7],
            mdl[8'h2E][7], mdl[8'h2D][7], mdl[8'h2C][7], eff()};
        else er = 2'h2;
        axi_read({idx, 2'b00}, d, r);
        chk_bus("rdata", e, d);
        chk_bus("rresp", 32'(er), 32'(r));
    endtask

    task automatic after_reset();
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[8'h2C] = 8'h80;
        @(posedge aclk);
        check_outs();
        for (int i = 8'h28; i < 8'h33; i++) rd(8'(i));
        $display("test reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        int c;
        void'($urandom(63));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        after_reset();
        // Every output-stage code, about one in five with its route left off
        for (c = 0; c < 128; c++) begin
            wr(8'h2D + 8'($urandom_range(3)), {24'($urandom), c % 5 != 0, 7'(c)}, 4'hF);
        end
        for (c = 8'h2D; c < 8'h31; c++) rd(8'(c));
        $display("test route sweep done");
        for (c = 0; c < 12; c++) begin
            wr(dvhm_pkg::IDX_RIGHT_VOL, c < 2 ? 32'(c * 8'h7F) : $urandom, 4'hF);
        end
        $display("test right volume done");
        for (c = 0; c < 16; c++) begin
            if (c % 4 == 0) wr(dvhm_pkg::IDX_COUPLE, 32'(c / 4), 4'hF);
            left_gain <= 7'($urandom);
            repeat (2) @(posedge aclk);
            check_outs();
            rd(dvhm_pkg::IDX_STATUS);
        end
        $display("test coupling done");
        // Read-only, unmapped and masked writes must leave the bank alone
        wr(dvhm_pkg::IDX_STATUS, 32'hFF, 4'hF);
        wr(8'h00, 32'hFF, 4'hF);
        wr(8'hFF, 32'hFF, 4'hF);
        wr(dvhm_pkg::IDX_RIGHT_VOL, 32'h55, 4'hE);
        rd(8'hFF);
        rd(dvhm_pkg::IDX_RIGHT_VOL);
        $display("test refusals done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        after_reset();
        finish_test();
    end

    // Whole run is under two thousand cycles; this span leaves ample margin
    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        $display("MISMATCH watchdog expected end seen timeout");
        finish_test();
    end
endmodule
